// ### hdl/video_tv_blank_regs.sv
// video processor register bank, tv-out vertical blank and filter clamp
// assumes register port and pixel stream are on clk; tv pins are async
// tv timing is recovered on clk
`timescale 1ns/100ps

module video_tv_blank_regs (
  input  wire logic                      clk,             // 100 MHz core clock
  input  wire logic                      nrst,            // sync reset, active low
  // register port
  input  wire logic [7:0]                io_addr,         // byte address
  input  wire logic                      io_wr,           // write strobe
  input  wire logic                      io_rd,           // read strobe
  input  wire logic [3:0]                io_be,           // byte enables
  input  wire logic [31:0]               io_wdata,        // write data
  output logic      [31:0]               io_rdata,        // read data
  output logic                           io_rvalid,       // read data valid

  // live status for read-only registers
  input  wire logic [18:0]               status_line_in,  // scan line and status
  input  wire logic [23:0]               overlay_addr_in, // overlay address in use

  // tv pins
  input  wire logic                      tv_input_clock,  // tv clock pin
  input  wire logic                      tv_line_sync,    // tv line sync pin
  input  wire logic                      tv_frame_sync,   // tv frame sync pin
  input  wire logic                      hblank_n_in,     // horizontal blank, low
  output logic                           blank_n,         // combined blank, low

  // pixel clamp path
  input  wire logic                      pix_valid,       // neighbour pixel valid
  input  wire video_tv_blank_pkg::pixel_s pix_in,         // neighbour pixel
  input  wire video_tv_blank_pkg::pixel_s pix_centre,     // centre pixel
  output logic                           pix_out_valid,   // clamped pixel valid
  output video_tv_blank_pkg::pixel_s     pix_out,         // clamped pixel

  // configuration out
  output logic      [31:0]               proc_config,     // processor config
  output logic      [18:0]               overlay_offset,  // horizontal init offset
  output logic      [12:0]               overlay_src_width // source width
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // address to register index, shared by read and write paths
  // no match: hit low, reads zero
  function automatic video_tv_blank_pkg::reg_hit_s lookup(input logic [7:0] a);
    video_tv_blank_pkg::reg_hit_s h;
    h = '0;
    for (int k = 0; k < video_tv_blank_pkg::NUM_REGS; k++) begin
      if (a == video_tv_blank_pkg::REG_OFFSET[k]) begin
        h.hit = 1'b1;
        h.idx = k[$clog2(video_tv_blank_pkg::NUM_REGS)-1:0];
      end
    end
    return h;
  endfunction : lookup

  // implemented-bit mask from a width
  // 33 bits cover a full 32-bit width
  function automatic logic [31:0] width_mask(input int w);
    logic [32:0] m;
    m = (33'h1 << w) - 33'h1;
    return m[31:0];
  endfunction : width_mask

  // byte-lane merge of a write
  // disabled lanes keep their byte
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // one component: keep if close to centre, else take centre
  // a delta equal to thr is kept
  function automatic logic [7:0] clamp(input logic [7:0] c,
                                       input logic [7:0] ctr,
                                       input logic [5:0] thr);
    logic [7:0] d;
    d = (c > ctr) ? c - ctr : ctr - c;
    return (d > {2'h0, thr}) ? ctr : c;
  endfunction : clamp

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  // unpacked: one process per word
  logic [31:0]                       regs_q [video_tv_blank_pkg::NUM_REGS]; // the bank
  video_tv_blank_pkg::reg_hit_s      wr_hit;  // decoded write target
  video_tv_blank_pkg::reg_hit_s      rd_hit;  // decoded read target

  // one decoder: both share io_addr
  assign wr_hit = lookup(io_addr);
  assign rd_hit = wr_hit;

  // one storage process per register; read-only ones track live status
  for (genvar i = 0; i < video_tv_blank_pkg::NUM_REGS; i++) begin : g_reg
    localparam logic [31:0] MASK = (i == video_tv_blank_pkg::IDX_VBLANK) ?
      video_tv_blank_pkg::VBLANK_MASK : width_mask(video_tv_blank_pkg::REG_WIDTH[i]);

    if (i == video_tv_blank_pkg::IDX_STATUS) begin : g_status
      // [RQ11] status is read-only
      always_ff @(posedge clk) begin
        if (!nrst) regs_q[i] <= video_tv_blank_pkg::REG_RESET;
        else       regs_q[i] <= {13'h0, status_line_in};
      end
    end else if (i == video_tv_blank_pkg::IDX_OVLADDR) begin : g_ovl
      // [RQ11] overlay address is read-only
      always_ff @(posedge clk) begin
        if (!nrst) regs_q[i] <= video_tv_blank_pkg::REG_RESET;
        else       regs_q[i] <= {8'h0, overlay_addr_in};
      end
    end else begin : g_rw
      // writable word; reserved and unimplemented bits never stored
      // [RQ7] reserved bits masked off
      always_ff @(posedge clk) begin
        if (!nrst) begin
          regs_q[i] <= video_tv_blank_pkg::REG_RESET;
        end else if (io_wr && wr_hit.hit && (wr_hit.idx == i)) begin
          regs_q[i] <= merge(regs_q[i], io_wdata, io_be) & MASK;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------

  // data one cycle after the strobe; unmapped addresses read zero
  // read beside write sees old word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      io_rdata  <= 32'h0;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        io_rdata <= rd_hit.hit ? regs_q[rd_hit.idx] : 32'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------
  // plain slices, no extra flops
  logic [10:0] vb_start;   // first active line count
  logic [10:0] vb_end;     // first blank line count again
  logic        genlock;    // tv genlock in force
  logic [1:0]  fmode;      // overlay filter mode
  logic [5:0]  thr_r;      // red/y threshold
  logic [5:0]  thr_g;      // green/u threshold
  logic [5:0]  thr_b;      // blue/v threshold

  // [RQ2] start field
  assign vb_start = regs_q[video_tv_blank_pkg::IDX_VBLANK][video_tv_blank_pkg::VB_START_LSB +:
                    video_tv_blank_pkg::LINE_W];

  // [RQ3] end field
  assign vb_end   = regs_q[video_tv_blank_pkg::IDX_VBLANK][video_tv_blank_pkg::VB_END_LSB +:
                    video_tv_blank_pkg::LINE_W];

  // [RQ1] both format bits needed
  assign genlock  = regs_q[video_tv_blank_pkg::IDX_INFMT][video_tv_blank_pkg::GENLOCK_BIT] &
                    regs_q[video_tv_blank_pkg::IDX_INFMT][video_tv_blank_pkg::TVOUT_BIT];
  assign fmode    = regs_q[video_tv_blank_pkg::IDX_CFG][video_tv_blank_pkg::FMODE_LSB +: 2];

  // [RQ9] threshold fields
  assign thr_b    = regs_q[video_tv_blank_pkg::IDX_DELTA][video_tv_blank_pkg::THR_B_LSB +:
                    video_tv_blank_pkg::THR_W];
  assign thr_g    = regs_q[video_tv_blank_pkg::IDX_DELTA][video_tv_blank_pkg::THR_G_LSB +:
                    video_tv_blank_pkg::THR_W];
  assign thr_r    = regs_q[video_tv_blank_pkg::IDX_DELTA][video_tv_blank_pkg::THR_R_LSB +:
                    video_tv_blank_pkg::THR_W];

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------
  // straight from the stored word
  assign proc_config = regs_q[video_tv_blank_pkg::IDX_CFG];

  // [RQ10] offset and width split
  assign overlay_offset    = regs_q[video_tv_blank_pkg::IDX_OFFSRC][video_tv_blank_pkg::OFFS_W-1:0];
  assign overlay_src_width = regs_q[video_tv_blank_pkg::IDX_OFFSRC][video_tv_blank_pkg::SRCW_LSB +:
                             video_tv_blank_pkg::SRCW_W];

  // ------------------------------------------------------------
  // tv pin synchronisers
  // ------------------------------------------------------------
  video_tv_blank_pkg::tv_pins_s pins_meta;  // first stage, read by second only
  video_tv_blank_pkg::tv_pins_s pins_sync;  // safe copy
  logic                         tv_clk_d;   // tv clock one cycle ago

  // two flops on every tv pin before any logic looks at them
  // tv clock is data, never a clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= '{clk: tv_input_clock, line: tv_line_sync,
                     frame: tv_frame_sync, hblank_n: hblank_n_in};
      pins_sync <= pins_meta;
    end
  end

  // tv clock edge finder; 125 ns period leaves ~6 core cycles per half
  // half periods under 1 cycle can drop ticks
  always_ff @(posedge clk) begin
    if (!nrst) tv_clk_d <= 1'b0;
    else       tv_clk_d <= pins_sync.clk;
  end

  logic tv_tick;  // one-cycle enable at each rising tv clock
  // [RQ6] pace from tv clock edges
  assign tv_tick = pins_sync.clk & ~tv_clk_d;

  // ------------------------------------------------------------
  // sync edge detection on tv clock ticks
  // ------------------------------------------------------------
  logic line_q;    // line sync sampled at last tick
  logic frame_q;   // frame sync sampled at last tick

  // syncs sampled only on tv clock edges, as the encoder launches them
  // a long sync still gives one rise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_q  <= 1'b0;
      frame_q <= 1'b0;
    end else if (tv_tick) begin
      line_q  <= pins_sync.line;
      frame_q <= pins_sync.frame;
    end
  end


  // pulses only on tick cycles
  logic line_rise;   // rising line sync this tick
  logic frame_rise;  // rising frame sync this tick
  assign line_rise  = tv_tick & pins_sync.line & ~line_q;
  assign frame_rise = tv_tick & pins_sync.frame & ~frame_q;

  // ------------------------------------------------------------
  // vertical blank generation
  // ------------------------------------------------------------
  logic [10:0] line_cnt_reg;  // line edges since frame edge
  logic [10:0] line_cnt_next; // count after this line edge
  logic        vblank_n_reg;  // vertical blank, active low

  // next count, shared by compares
  assign line_cnt_next = (line_cnt_reg == 11'h7ff) ? line_cnt_reg : line_cnt_reg + 11'h1;

  // counter saturates so a missing frame sync cannot reopen the window
  // leaving genlock clears the count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_cnt_reg <= 11'h0;
    end else if (!genlock) begin
      line_cnt_reg <= 11'h0;
    // [RQ13] restart on frame edge
    end else if (frame_rise) begin
      line_cnt_reg <= 11'h0;
    end else if (line_rise) begin
      line_cnt_reg <= line_cnt_next;
    end
  end

  // vertical blank state; frame edge wins over a coincident line edge
  // counts compared live, not latched
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vblank_n_reg <= 1'b1;
    // [RQ1] no vertical blanking outside genlock
    end else if (!genlock) begin
      vblank_n_reg <= 1'b1;
    // [RQ13] blank from frame edge
    end else if (frame_rise) begin
      vblank_n_reg <= (vb_start == 11'h0);
    end else if (line_rise) begin
      // [RQ5] end above start assumed; end checked last so it wins
      if (line_cnt_next == vb_start) begin
        // [RQ2] active region opens
        vblank_n_reg <= 1'b1;
      end
      if (line_cnt_next == vb_end) begin
        // [RQ3] blanking resumes
        vblank_n_reg <= 1'b0;
      end
    end
  end

  // combined blank, registered for a clean output
  // one more core cycle on hblank
  always_ff @(posedge clk) begin
    if (!nrst) begin
      blank_n <= 1'b0;
    end else begin
      // [RQ4] and of both blanks
      blank_n <= pins_sync.hblank_n & vblank_n_reg;
    end
  end

  // ------------------------------------------------------------
  // filter input clamp
  // ------------------------------------------------------------
  logic clamp_on;  // a clamping filter is selected

  // [RQ12] box or tap only
  assign clamp_on = (fmode == video_tv_blank_pkg::FMODE_BOX) ||
                    (fmode == video_tv_blank_pkg::FMODE_TAP);

  // one stage of latency; other filter modes pass the pixel untouched
  // centre and neighbour come together
  // pix_out holds between pixels
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pix_out_valid <= 1'b0;
      pix_out       <= '0;
    end else begin
      pix_out_valid <= pix_valid;
      if (pix_valid) begin
        if (clamp_on) begin
          // [RQ8] per-component outlier replace
          pix_out.r <= clamp(pix_in.r, pix_centre.r, thr_r);
          pix_out.g <= clamp(pix_in.g, pix_centre.g, thr_g);
          pix_out.b <= clamp(pix_in.b, pix_centre.b, thr_b);
        end else begin
          pix_out <= pix_in;
        end
      end
    end
  end

endmodule : video_tv_blank_regs

// ### hdl/video_tv_blank_pkg.sv
// shared constants and types for the video register bank and tv blank logic
// assumes a single 100 MHz core clock; tv pins arrive asynchronously
//
// Overview of operation
// [RQ1] count vertical blank only in tv genlock
// [RQ2] end vertical blank at start line count
// [RQ3] restart vertical blank at end line count
// [RQ4] blank output is horizontal AND vertical blank
// [RQ5] software keeps end count above start count
// [RQ6] counting paced by the tv input clock
// [RQ7] reserved count bits ignored, read as zero
// [RQ8] clamp outlying components to centre before filtering
// [RQ9] thresholds at 5:0, 13:8, 21:16
// [RQ10] offset in 18:0, source width 31:19
// [RQ11] status and overlay address registers read-only
// [RQ12] filter codes: 01 box, 10 tap
// [RQ13] line counter restarts at each frame sync
package video_tv_blank_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int NUM_REGS = 31;                   // words in the bank
  localparam int ADDR_W   = 8;                    // byte address width
  localparam logic [31:0] REG_RESET = 32'h0000_0000; // every register resets clear

  // byte offsets, in index order
  localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
    8'h3c, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h74, 8'h78, 8'h7c,
    8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8,
    8'hac, 8'he0, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4, 8'hf8, 8'hfc};

  // implemented width of each register, bits above read zero
  localparam int REG_WIDTH [NUM_REGS] = '{
    32, 24, 32, 24, 27, 24, 24, 32, 32, 32, 32,
    32, 32, 18, 32, 32, 19, 24, 32, 24, 20, 32,
    20, 19, 24, 32, 24, 24, 24, 15, 24};

  // indices of registers the logic looks at
  localparam int IDX_VBLANK  = 0;   // tv_out_vertical_blank_count
  localparam int IDX_DELTA   = 1;   // filter_max_component_delta
  localparam int IDX_CFG     = 2;   // video_processor_config
  localparam int IDX_INFMT   = 7;   // video_input_format
  localparam int IDX_STATUS  = 16;  // input_status_scan_line
  localparam int IDX_OFFSRC  = 21;  // overlay_horiz_offset_src_width
  localparam int IDX_OVLADDR = 30;  // current_overlay_address

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam logic [31:0] VBLANK_MASK = 32'h07ff_07ff; // reserved bits dropped
  localparam int VB_START_LSB = 0;
  localparam int VB_END_LSB   = 16;
  localparam int LINE_W       = 11;  // width of start/end counts
  localparam int GENLOCK_BIT  = 16;  // genlock enable in input format
  localparam int TVOUT_BIT    = 18;  // tv-out select in input format
  localparam int THR_B_LSB    = 0;
  localparam int THR_G_LSB    = 8;
  localparam int THR_R_LSB    = 16;
  localparam int THR_W        = 6;
  localparam int FMODE_LSB    = 16;  // overlay filter mode in config
  localparam logic [1:0] FMODE_BOX = 2'h1;
  localparam logic [1:0] FMODE_TAP = 2'h2;
  localparam int OFFS_W       = 19;  // horizontal initial offset width
  localparam int SRCW_LSB     = 19;
  localparam int SRCW_W       = 13;  // source surface width field

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] r;  // red or luma
    logic [7:0] g;  // green or u/cb
    logic [7:0] b;  // blue or v/cr
  } pixel_s;

  typedef struct packed {
    logic clk;       // tv input clock
    logic line;      // tv line sync
    logic frame;     // tv frame sync
    logic hblank_n;  // horizontal blank, active low
  } tv_pins_s;

  typedef struct packed {
    logic                       hit;  // address maps to a register
    logic [$clog2(NUM_REGS)-1:0] idx; // its index
  } reg_hit_s;

endpackage : video_tv_blank_pkg

// ### dv/tv_encoder_model.sv
// tv encoder stand-in driving the tv clock and sync pins
// assumes the bench calls its tasks; the tv clock rests low between ticks
`timescale 1ns/100ps
module tv_encoder_model (
  output logic tv_input_clock, // tv clock pin
  output logic tv_line_sync,   // line sync pin
  output logic tv_frame_sync   // frame sync pin
);
  // pins idle low until the first tick
  initial begin
    tv_input_clock = 1'b0;
    tv_line_sync   = 1'b0;
    tv_frame_sync  = 1'b0;
  end
  // syncs ride one tv clock period
  task automatic tick(input logic f, input logic l);
    tv_line_sync  = l;
    tv_frame_sync = f;
    #62.5;
    tv_input_clock = 1'b1;
    #62.5;
    tv_input_clock = 1'b0;
  endtask : tick
  // line pulse while the tv clock rests; must not count
  task automatic raw_line;
    tv_line_sync = 1'b1;
    #40;
    tv_line_sync = 1'b0;
  endtask : raw_line
endmodule : tv_encoder_model

// ### dv/video_tv_blank_regs_assertions.sv
// port checker for the register bank, pixel clamp and blank output
// assumes one clk domain; bound onto video_tv_blank_regs
`timescale 1ns/100ps
module video_tv_blank_regs_assertions (
  input wire logic                       clk,               // core clock
  input wire logic                       nrst,              // reset, low
  input wire logic [7:0]                 io_addr,           // address
  input wire logic                       io_wr,             // write strobe
  input wire logic                       io_rd,             // read strobe
  input wire logic [3:0]                 io_be,             // byte enables
  input wire logic [31:0]                io_wdata,          // write data
  input wire logic [31:0]                io_rdata,          // read data
  input wire logic                       io_rvalid,         // read valid
  input wire logic [18:0]                status_line_in,    // live status
  input wire logic                       hblank_n_in,       // hblank pin
  input wire logic                       blank_n,           // blank out
  input wire logic                       pix_valid,         // pixel strobe
  input wire video_tv_blank_pkg::pixel_s pix_in,            // neighbour
  input wire video_tv_blank_pkg::pixel_s pix_centre,        // centre
  input wire logic                       pix_out_valid,     // out strobe
  input wire video_tv_blank_pkg::pixel_s pix_out,           // clamped
  input wire logic [31:0]                proc_config,       // config
  input wire logic [18:0]                overlay_offset,    // offset
  input wire logic [12:0]                overlay_src_width  // width
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (io_rd |=> io_rvalid)
    else $error("read not answered");
  rd_cause_a: assert property (io_rvalid |-> $past(io_rd))
    else $error("read valid without read");
  rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without read");
  ro_status_a: assert property ($past(nrst) && io_rd && io_addr == 8'h94 && $stable(status_line_in)
    |=> io_rdata == {13'h0, $past(status_line_in)}) else $error("status read wrong");
  offs_pack_a: assert property (io_wr && io_addr == 8'ha8 && io_be == 4'hf
    |=> {overlay_src_width, overlay_offset} == $past(io_wdata)) else $error("offset fields wrong");
  pix_lat_a: assert property (pix_valid |=> pix_out_valid)
    else $error("pixel not answered");
  pix_pass_a: assert property (pix_valid && proc_config[17] == proc_config[16]
    |=> pix_out == $past(pix_in)) else $error("pixel altered outside filter modes");
  clamp_pick_a: assert property (pix_valid |=> pix_out.r == $past(pix_in.r)
    || pix_out.r == $past(pix_centre.r)) else $error("red from neither pixel");
  hblank_a: assert property ($past(nrst, 4) && !$past(hblank_n_in, 3) |-> !blank_n)
    else $error("blank high during hblank");
  cover property (io_rd && io_addr == 8'h94);
  cover property (pix_valid && proc_config[17:16] == 2'h2);
  cover property ($rose(blank_n));
endmodule : video_tv_blank_regs_assertions
bind video_tv_blank_regs video_tv_blank_regs_assertions chk_i (.clk, .nrst, .io_addr, .io_wr, .io_rd,
  .io_be, .io_wdata, .io_rdata, .io_rvalid, .status_line_in, .hblank_n_in, .blank_n, .pix_valid, .pix_in,
  .pix_centre, .pix_out_valid, .pix_out, .proc_config, .overlay_offset, .overlay_src_width);

// ### dv/video_tv_blank_regs_tb.sv
// self-checking bench: register map, pixel clamp, tv vertical blank
// assumes tv_encoder_model drives the tv clock and sync pins; hblank and host traffic from here
`timescale 1ns/100ps
module video_tv_blank_regs_tb;
  logic                       clk, nrst;                     // clock, reset
  logic [7:0]                 io_addr;                       // address
  logic                       io_wr, io_rd, io_rvalid;       // strobes
  logic [3:0]                 io_be;                         // lanes
  logic [31:0]                io_wdata, io_rdata;            // data
  logic                       tv_input_clock, tv_line_sync;  // tv pins
  logic                       tv_frame_sync, hblank_n_in;    // tv pins
  logic                       blank_n, pix_valid, pix_out_valid; // misc
  video_tv_blank_pkg::pixel_s pix_in, pix_centre, pix_out;   // pixels
  logic [31:0]                proc_config;                   // config
  logic [18:0]                overlay_offset;                // offset
  logic [12:0]                overlay_src_width;             // width
  logic [18:0]                status_line_in;                // live status
  logic [23:0]                overlay_addr_in;               // live address
  int                         n_errors, compares;            // tallies
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  video_tv_blank_regs uut (.clk, .nrst, .io_addr, .io_wr, .io_rd, .io_be, .io_wdata, .io_rdata, .io_rvalid,
    .status_line_in, .overlay_addr_in, .tv_input_clock, .tv_line_sync, .tv_frame_sync, .hblank_n_in,
    .blank_n, .pix_valid, .pix_in, .pix_centre, .pix_out_valid, .pix_out, .proc_config, .overlay_offset,
    .overlay_src_width);
  tv_encoder_model tv (.tv_input_clock, .tv_line_sync, .tv_frame_sync);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_be    <= be;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr    <= 1'b0;
  endtask : wr
  // read and compare; answer lands one cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd   <= 1'b0;
    #1;
    chk("read valid", 32'h1, {31'h0, io_rvalid});
    chk($sformatf("reg %h", a), exp, io_rdata);
  endtask : rc
  task automatic px(input logic [23:0] a, input logic [23:0] c, input logic [23:0] exp);
    @(posedge clk);
    pix_in     <= a;
    pix_centre <= c;
    pix_valid  <= 1'b1;
    @(posedge clk);
    pix_valid  <= 1'b0;
    #1;
    chk("pixel valid", 32'h1, {31'h0, pix_out_valid});
    chk("pixel", {8'h0, exp}, {8'h0, pix_out});
  endtask : px
  // tv tick carrying syncs, a quiet tick, then the blank level
  task automatic tvs(input logic f, input logic l, input logic e);
    tv.tick(f, l);
    tv.tick(1'b0, 1'b0);
    @(posedge clk);
    #1;
    chk("blank", {31'h0, e}, {31'h0, blank_n});
  endtask : tvs
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] m, live;
    for (int i = 0; i < video_tv_blank_pkg::NUM_REGS; i++) begin
      m = (video_tv_blank_pkg::REG_WIDTH[i] == 32) ? 32'hffff_ffff
        : (32'h1 << video_tv_blank_pkg::REG_WIDTH[i]) - 32'h1;
      if (i == 0) m = 32'h07ff_07ff;
      live = (i == 16) ? {13'h0, status_line_in} : (i == 30) ? {8'h0, overlay_addr_in} : 32'h0;
      rc(video_tv_blank_pkg::REG_OFFSET[i], live);
      wr(video_tv_blank_pkg::REG_OFFSET[i], 32'hffff_ffff, 4'hf);
      rc(video_tv_blank_pkg::REG_OFFSET[i], (i == 16 || i == 30) ? live : m);
    end
    wr(8'h40, 32'hffff_ffff, 4'hf);
    rc(8'h40, 32'h0);
    wr(8'h5c, 32'h0, 4'hf);
    wr(8'h5c, 32'h1234_5678, 4'h2);
    rc(8'h5c, 32'h0000_5600);
    chk("config out", 32'h0000_5600, proc_config);
    wr(8'ha8, 32'h89ab_cdef, 4'hf);
    @(posedge clk);
    chk("offset", 32'h0003_cdef, {13'h0, overlay_offset});
    chk("src width", 32'h0000_1135, {19'h0, overlay_src_width});
  endtask : t_regs
  // thresholds red 4, green 8, blue 16; green sits exactly on its limit
  task automatic t_clamp;
    wr(8'h58, 32'h0004_0810, 4'hf);
    for (int m = 0; m < 4; m++) begin
      wr(8'h5c, {14'h0, 2'(m), 16'h0}, 4'hf);
      px(24'h0a1225, 24'h140a14, (m == 1 || m == 2) ? 24'h141214 : 24'h0a1225);
    end
  endtask : t_clamp
  task automatic t_blank;
    wr(8'h70, 32'h0001_0000, 4'hf);
    wr(8'h3c, 32'h0004_0002, 4'hf);
    tvs(1'b1, 1'b0, 1'b1);
    wr(8'h70, 32'h0004_0000, 4'hf);
    tvs(1'b1, 1'b0, 1'b1);
    wr(8'h70, 32'h0005_0000, 4'hf);
    tvs(1'b1, 1'b0, 1'b0);
    tvs(1'b0, 1'b1, 1'b0);
    tv.raw_line();
    tvs(1'b0, 1'b0, 1'b0);
    tvs(1'b0, 1'b1, 1'b1);
    tvs(1'b0, 1'b1, 1'b1);
    tvs(1'b0, 1'b1, 1'b0);
    tvs(1'b1, 1'b0, 1'b0);
    tvs(1'b0, 1'b1, 1'b0);
    tvs(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    hblank_n_in <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("blank with hblank", 32'h0, {31'h0, blank_n});
  endtask : t_blank
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // watchdog well beyond the expected few microseconds
  initial begin
    #300us;
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    final_report();
  end
  // main sequence
  initial begin
    nrst            = 1'b0;
    io_addr         = 8'h0;
    io_wr           = 1'b0;
    io_rd           = 1'b0;
    io_be           = 4'h0;
    io_wdata        = 32'h0;
    status_line_in  = 19'h5a5a5;
    overlay_addr_in = 24'h3c5a96;
    hblank_n_in     = 1'b1;
    pix_valid       = 1'b0;
    pix_in          = 24'h0;
    pix_centre      = 24'h0;
    n_errors        = 0;
    compares        = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_clamp();
    t_blank();
    final_report();
  end
endmodule : video_tv_blank_regs_tb
